// [src/can_filt_pkg.sv]
// Constants for the acceptance filter configuration bank
package can_filt_pkg;
    localparam int NUM_FILTERS = 8;
    localparam int ADDR_W      = 8;
    localparam int PAGE_W      = 3;
    // Register offsets within the paged window
    localparam logic [7:0] OFF_MODE_LOWER = 8'h00F0;
    localparam logic [7:0] OFF_MODE_UPPER = 8'h00F1;
    localparam logic [7:0] OFF_CFG_PAIR0  = 8'h00F2;
    localparam logic [7:0] OFF_CFG_PAIR1  = 8'h00F3;
    localparam logic [7:0] OFF_CFG_PAIR2  = 8'h00F4;
    localparam logic [7:0] OFF_CFG_PAIR3  = 8'h00F5;
    localparam logic [7:0] OFF_TS_HIGH    = 8'h00FF;
    localparam logic [7:0] OFF_ID_BASE    = 8'h00F0;
    // Pages that show the configuration registers
    localparam logic [2:0] PAGE_CFG_MIN   = 3'h4;
    // Field positions inside a configuration nibble
    localparam int FLD_ACTIVE = 0;
    localparam int FLD_SCALE_LO = 1;
    localparam int FLD_FIFO   = 3;
    localparam int NIBBLE_W   = 4;
    localparam logic [7:0] CFG_RESET = 8'h0000;
    localparam logic [7:0] TS_RESET  = 8'h0000;
endpackage : can_filt_pkg

// [src/filter_decode.sv]
// Per-filter view of the configuration and mode registers
`timescale 1ns/1ps
module filter_decode
#(
    parameter int NUM_FILTERS = 8
)
(
    input  wire logic [8*NUM_FILTERS/2-1:0] cfg_bits,
    input  wire logic [2*NUM_FILTERS-1:0]   mode_bits,
    output logic      [NUM_FILTERS-1:0]     fifo_sel,
    output logic      [2*NUM_FILTERS-1:0]   scale,
    output logic      [NUM_FILTERS-1:0]     active,
    output logic      [NUM_FILTERS-1:0]     high_list,
    output logic      [NUM_FILTERS-1:0]     low_list
);
    genvar f;
    generate
        for (f = 0; f < NUM_FILTERS; f++)
        begin : g_filt
            localparam int B = f * can_filt_pkg::NIBBLE_W;
            assign fifo_sel[f] = cfg_bits[B + can_filt_pkg::FLD_FIFO];
            assign scale[2*f +: 2] =
                cfg_bits[B + can_filt_pkg::FLD_SCALE_LO +: 2];
            assign active[f] = cfg_bits[B + can_filt_pkg::FLD_ACTIVE];
            assign high_list[f] = mode_bits[2*f + 1];
            assign low_list[f]  = mode_bits[2*f];
        end
    endgenerate
endmodule : filter_decode

// [src/can_acceptance_filter_config.sv]
// Acceptance filter configuration and mode register bank
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module can_acceptance_filter_config
#(
    parameter int NUM_FILTERS = 8
)
(
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic [7:0]               addr,
    input  wire logic [7:0]               wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    input  wire logic [2:0]               filter_page_select,
    input  wire logic                     setup_mode,
    input  wire logic                     sof_capture,
    input  wire logic [15:0]              timer_value,
    output logic      [7:0]               rdata,
    output logic      [NUM_FILTERS-1:0]   filter_fifo_select,
    output logic      [2*NUM_FILTERS-1:0] filter_scale_cfg,
    output logic      [NUM_FILTERS-1:0]   filter_active_flag,
    output logic      [NUM_FILTERS-1:0]   filter_high_half_mode,
    output logic      [NUM_FILTERS-1:0]   filter_low_half_mode,
    output logic                          id_write_en,
    output logic      [2:0]               id_write_filter,
    output logic      [2:0]               id_write_index,
    output logic      [7:0]               id_write_data
);
    localparam int NPAIR = NUM_FILTERS / 2;

    logic [7:0] cfg_reg  [NPAIR];
    logic [7:0] cfg_next [NPAIR];
    logic [7:0] mode_reg [2];
    logic [7:0] mode_next[2];
    logic [7:0] ts_high_reg;
    logic [7:0] ts_high_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       idw_en_reg;
    logic       idw_en_next;
    logic [2:0] idw_filt_reg;
    logic [2:0] idw_filt_next;
    logic [2:0] idw_idx_reg;
    logic [2:0] idw_idx_next;
    logic [7:0] idw_data_reg;
    logic [7:0] idw_data_next;

    logic [8*NPAIR-1:0]       cfg_flat;
    logic [2*NUM_FILTERS-1:0] mode_flat;
    logic [NUM_FILTERS-1:0]   fifo_w;
    logic [2*NUM_FILTERS-1:0] scale_w;
    logic [NUM_FILTERS-1:0]   active_w;
    logic [NUM_FILTERS-1:0]   high_w;
    logic [NUM_FILTERS-1:0]   low_w;

    // Configuration page shown when page select is 4..7
    function automatic logic on_cfg_page(input logic [2:0] pg);
        on_cfg_page = (pg >= can_filt_pkg::PAGE_CFG_MIN);
    endfunction : on_cfg_page

    // Merge a config write: FIFO and scale bits held outside setup
    function automatic logic [7:0] cfg_merge(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic       setup);
        logic [7:0] keep;
        keep = 8'h0011;
        if (setup)
        begin
            cfg_merge = new_v;
        end
        else
        begin
            cfg_merge = (new_v & keep) | (old_v & ~keep);
        end
    endfunction : cfg_merge

    genvar p;
    generate
        for (p = 0; p < NPAIR; p++)
        begin : g_flat
            assign cfg_flat[8*p +: 8] = cfg_reg[p];
        end
    endgenerate
    assign mode_flat = {mode_reg[1], mode_reg[0]};

    filter_decode #(
        .NUM_FILTERS (NUM_FILTERS)
    ) u_decode (
        .cfg_bits    (cfg_flat),
        .mode_bits   (mode_flat),
        .fifo_sel    (fifo_w),
        .scale       (scale_w),
        .active      (active_w),
        .high_list   (high_w),
        .low_list    (low_w)
    );

    // Register write and read path
    always_comb
    begin
        logic [2:0] id_filt;
        id_filt = 3'h0;
        for (int i = 0; i < NPAIR; i++)
        begin
            cfg_next[i] = cfg_reg[i];
        end
        mode_next[0]  = mode_reg[0];
        mode_next[1]  = mode_reg[1];
        ts_high_next  = ts_high_reg;
        rdata_next    = 8'h0000;
        idw_en_next   = 1'b0;
        idw_filt_next = idw_filt_reg;
        idw_idx_next  = idw_idx_reg;
        idw_data_next = idw_data_reg;

        if (sof_capture)
        begin
            ts_high_next = timer_value[15:8];
        end

        // Bits below change only on a software write, except ts_high_reg, which sof_capture also loads above
        if (wr)
        begin
            if (addr == can_filt_pkg::OFF_TS_HIGH)
            begin
                ts_high_next = wdata;
            end
            else if (on_cfg_page(filter_page_select))
            begin
                case (addr)
                    can_filt_pkg::OFF_MODE_LOWER: mode_next[0] = wdata;
                    can_filt_pkg::OFF_MODE_UPPER: mode_next[1] = wdata;
                    can_filt_pkg::OFF_CFG_PAIR0:
                        cfg_next[0] = cfg_merge(cfg_reg[0], wdata,
                                                setup_mode);
                    can_filt_pkg::OFF_CFG_PAIR1:
                        cfg_next[1] = cfg_merge(cfg_reg[1], wdata,
                                                setup_mode);
                    can_filt_pkg::OFF_CFG_PAIR2:
                        cfg_next[2] = cfg_merge(cfg_reg[2], wdata,
                                                setup_mode);
                    can_filt_pkg::OFF_CFG_PAIR3:
                        cfg_next[3] = cfg_merge(cfg_reg[3], wdata,
                                                setup_mode);
                    default: ;
                endcase
            end
            else if (addr >= can_filt_pkg::OFF_ID_BASE)
            begin
                // Pages 0..3 hold id/mask registers of a filter pair
                id_filt = {filter_page_select[1:0], addr[3]};
                if (!active_w[id_filt])
                begin
                    idw_en_next   = 1'b1;
                    idw_filt_next = id_filt;
                    idw_idx_next  = addr[2:0];
                    idw_data_next = wdata;
                end
            end
        end

        if (rd)
        begin
            if (addr == can_filt_pkg::OFF_TS_HIGH)
            begin
                rdata_next = ts_high_reg;
            end
            else if (on_cfg_page(filter_page_select))
            begin
                case (addr)
                    can_filt_pkg::OFF_MODE_LOWER: rdata_next = mode_reg[0];
                    can_filt_pkg::OFF_MODE_UPPER: rdata_next = mode_reg[1];
                    can_filt_pkg::OFF_CFG_PAIR0:  rdata_next = cfg_reg[0];
                    can_filt_pkg::OFF_CFG_PAIR1:  rdata_next = cfg_reg[1];
                    can_filt_pkg::OFF_CFG_PAIR2:  rdata_next = cfg_reg[2];
                    can_filt_pkg::OFF_CFG_PAIR3:  rdata_next = cfg_reg[3];
                    default:                      rdata_next = 8'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NPAIR; i++)
            begin
                cfg_reg[i] <= can_filt_pkg::CFG_RESET;
            end
            mode_reg[0]  <= can_filt_pkg::CFG_RESET;
            mode_reg[1]  <= can_filt_pkg::CFG_RESET;
            ts_high_reg  <= can_filt_pkg::TS_RESET;
            rdata_reg    <= 8'h0000;
            idw_en_reg   <= 1'b0;
            idw_filt_reg <= 3'h0;
            idw_idx_reg  <= 3'h0;
            idw_data_reg <= 8'h0000;
        end
        else
        begin
            for (int i = 0; i < NPAIR; i++)
            begin
                cfg_reg[i] <= cfg_next[i];
            end
            mode_reg[0]  <= mode_next[0];
            mode_reg[1]  <= mode_next[1];
            ts_high_reg  <= ts_high_next;
            rdata_reg    <= rdata_next;
            idw_en_reg   <= idw_en_next;
            idw_filt_reg <= idw_filt_next;
            idw_idx_reg  <= idw_idx_next;
            idw_data_reg <= idw_data_next;
        end
    end

    // Decoded fields come from flip-flops through pure wiring
    assign rdata                 = rdata_reg;
    assign filter_fifo_select    = fifo_w;
    assign filter_scale_cfg      = scale_w;
    assign filter_active_flag    = active_w;
    assign filter_high_half_mode = high_w;
    assign filter_low_half_mode  = low_w;
    assign id_write_en           = idw_en_reg;
    assign id_write_filter       = idw_filt_reg;
    assign id_write_index        = idw_idx_reg;
    assign id_write_data         = idw_data_reg;
endmodule : can_acceptance_filter_config

// [sim/can_acceptance_filter_config_properties.sv]
// Port assertions for the filter configuration register bank
`timescale 1ns/1ps
module can_acceptance_filter_config_properties
#(
    parameter int NUM_FILTERS = 8
)
(
    input wire logic                     clk,
    input wire logic                     rst_n,
    input wire logic [7:0]               addr,
    input wire logic [7:0]               wdata,
    input wire logic                     wr,
    input wire logic                     rd,
    input wire logic [2:0]               filter_page_select,
    input wire logic                     setup_mode,
    input wire logic                     sof_capture,
    input wire logic [15:0]              timer_value,
    input wire logic [7:0]               rdata,
    input wire logic [NUM_FILTERS-1:0]   filter_fifo_select,
    input wire logic [2*NUM_FILTERS-1:0] filter_scale_cfg,
    input wire logic [NUM_FILTERS-1:0]   filter_active_flag,
    input wire logic [NUM_FILTERS-1:0]   filter_high_half_mode,
    input wire logic [NUM_FILTERS-1:0]   filter_low_half_mode,
    input wire logic                     id_write_en,
    input wire logic [2:0]               id_write_filter,
    input wire logic [2:0]               id_write_index,
    input wire logic [7:0]               id_write_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic [47:0] cfg_all = {filter_low_half_mode, filter_high_half_mode,
        filter_scale_cfg, filter_fifo_select, filter_active_flag};
    wire logic        cfg_wr  = wr && filter_page_select[2];
    logic      [7:0]  wd;
    always_ff @(posedge clk) wd <= wdata;
    property p_rst;
        $rose(rst_n) |-> cfg_all == 48'h0000_0000_0000;
    endproperty
    a_rst: assert property (p_rst) else $error("config not zero");
    property p_hold;
        !cfg_wr |=> $stable(cfg_all);
    endproperty
    a_hold: assert property (p_hold) else $error("config moved");
    property p_lock;
        !setup_mode |=> $stable({filter_fifo_select, filter_scale_cfg});
    endproperty
    a_lock: assert property (p_lock) else $error("locked bits moved");
    property p_act;
        cfg_wr && addr == 8'hF2 |=> filter_active_flag[1:0] == {wd[4], wd[0]};
    endproperty
    a_act: assert property (p_act) else $error("active bits");
    property p_fifo;
        cfg_wr && setup_mode && addr == 8'hF5 |=> {filter_fifo_select[7:6],
            filter_scale_cfg[15:12]} == {wd[7], wd[3], wd[6:5], wd[2:1]};
    endproperty
    a_fifo: assert property (p_fifo) else $error("fifo or scale");
    property p_mode;
        cfg_wr && addr == 8'hF0 |=> wd == {filter_high_half_mode[3],
            filter_low_half_mode[3], filter_high_half_mode[2],
            filter_low_half_mode[2], filter_high_half_mode[1],
            filter_low_half_mode[1], filter_high_half_mode[0],
            filter_low_half_mode[0]};
    endproperty
    a_mode: assert property (p_mode) else $error("mode bits");
    property p_read;
        rd && filter_page_select[2] && addr == 8'hF2 |=> rdata == {
            filter_fifo_select[1], filter_scale_cfg[3:2], filter_active_flag[1],
            filter_fifo_select[0], filter_scale_cfg[1:0], filter_active_flag[0]};
    endproperty
    a_read: assert property (p_read) else $error("read layout");
    property p_idlock;
        wr && !filter_page_select[2] && addr[7:4] == 4'hF && addr != 8'hFF
            && filter_active_flag[{filter_page_select[1:0], addr[3]}]
            |=> !id_write_en;
    endproperty
    a_idlock: assert property (p_idlock) else $error("id write taken");
endmodule : can_acceptance_filter_config_properties

bind can_acceptance_filter_config can_acceptance_filter_config_properties
    #(.NUM_FILTERS(NUM_FILTERS)) chk_u (.*);

// [sim/can_acceptance_filter_config_tb_top.sv]
// Random and directed bench for the filter configuration register bank
`timescale 1ns/1ps
module can_acceptance_filter_config_tb_top;
    logic        clk, rst_n, wr, rd, setup_mode, sof_capture, id_write_en;
    logic [2:0]  filter_page_select, id_write_filter, id_write_index, pg;
    logic [7:0]  addr, wdata, rdata, id_write_data, ts, a, d, m[6];
    logic [7:0]  filter_fifo_select, filter_active_flag;
    logic [7:0]  filter_high_half_mode, filter_low_half_mode;
    logic [15:0] timer_value, filter_scale_cfg;
    logic [47:0] e;
    int          num_errors, samples_checked, seed, k, n;

    always #20 clk = ~clk;

    can_acceptance_filter_config #(.NUM_FILTERS(8)) dut_u (.*);

    task chk(input logic [47:0] seen, exp, input string name);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task end_sim;
        if (num_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    task bus(input logic w, input logic [7:0] ad, dt);
        @(posedge clk);
        addr <= ad;
        wdata <= dt;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'h0;
        rd <= 1'h0;
        #1;
    endtask : bus

    // Expected per-filter outputs as {low, high, scale, fifo, active}
    function automatic logic [47:0] outs();
        logic [47:0] v;
        for (int i = 0; i < 8; i++)
        begin
            v[i] = m[2+i/2][4*(i%2)];
            v[8+i] = m[2+i/2][4*(i%2)+3];
            v[16+2*i+:2] = m[2+i/2][4*(i%2)+1+:2];
            v[32+i] = m[i/4][2*(i%4)+1];
            v[40+i] = m[i/4][2*(i%4)];
        end
        return v;
    endfunction : outs

    initial
    begin
        {clk, wr, rd, sof_capture, setup_mode} = 5'h01;
        {addr, wdata, timer_value} = 32'h0000_0000;
        filter_page_select = 3'h4;
        num_errors = 0;
        samples_checked = 0;
        seed = 23330;
        for (n = 0; n < 2; n++)
        begin
            rst_n <= 1'h0;
            repeat (16) @(posedge clk);
            rst_n <= 1'h1;
            m = '{default: 8'h00};
            ts = 8'h00;
            for (k = 0; k < 6; k++)
            begin
                bus(1'h0, 8'hF0 + 8'(k), 8'h00);
                chk(rdata, 8'h00, "reset value");
            end
            for (k = 0; k < 400; k++)
            begin
                pg = 3'($random(seed));
                a = {4'hF, 4'($random(seed))};
                d = 8'($random(seed));
                setup_mode <= 1'($random(seed));
                timer_value <= 16'($random(seed));
                e = outs();
                if (k % 3 == 0)
                begin
                    filter_page_select <= {1'h1, pg[1:0]};
                    bus(1'h0, a, 8'h00);
                    chk(rdata, a == 8'hFF ? ts : a < 8'hF6 ? m[a[2:0]] : 8'h00,
                        "read data");
                end
                else
                begin
                    pg[2] = pg[2] | (a == 8'hFF);
                    filter_page_select <= pg;
                    bus(1'h1, a, d);
                    if (a == 8'hFF)
                        ts = d;
                    else if (pg[2] && a < 8'hF2)
                        m[a[2:0]] = d;
                    else if (pg[2] && a < 8'hF6)
                        m[a[2:0]] = setup_mode ? d
                            : (m[a[2:0]] & 8'hEE) | (d & 8'h11);
                    chk(id_write_en, !pg[2] && !e[{pg[1:0], a[3]}],
                        "id strobe");
                    if (!pg[2] && !e[{pg[1:0], a[3]}])
                        chk({id_write_filter, id_write_index, id_write_data},
                            {pg[1:0], a[3:0], d}, "id fields");
                end
                chk({filter_low_half_mode, filter_high_half_mode,
                    filter_scale_cfg, filter_fifo_select, filter_active_flag},
                    outs(), "config");
            end
        end
        // Capture at frame start; a same-cycle software write wins
        filter_page_select <= 3'h6;
        for (k = 0; k < 4; k++)
        begin
            @(posedge clk);
            timer_value <= 16'($random(seed));
            sof_capture <= 1'h1;
            wr <= k[0];
            addr <= 8'hFF;
            wdata <= 8'h5A ^ 8'(k);
            @(posedge clk);
            sof_capture <= 1'h0;
            wr <= 1'h0;
            bus(1'h0, 8'hFF, 8'h00);
            chk(rdata, k[0] ? 8'h5A ^ 8'(k) : timer_value[15:8],
                "time stamp");
        end
        end_sim;
    end
endmodule : can_acceptance_filter_config_tb_top
